//--- hbmp_ctrl.sv
`timescale 1ns/1ps
module hbmp_ctrl
#(
  parameter int unsigned SLEEP_CYCLES = hbmp_pkg::SLEEP_CYC,
  parameter int unsigned DEG_CYCLES = hbmp_pkg::DEG_CYC,
  parameter int unsigned RETRY_CYCLES = hbmp_pkg::RETRY_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Direction inputs from host
  input wire logic dir_in_a,
  input wire logic dir_in_b,
  // Supply lockout comparators (rising above 2.5V, falling below 1.8V)
  input wire logic supply_above_rise,
  input wire logic supply_below_fall,
  // Fault detectors
  input wire logic overcurrent_det,
  input wire logic short_det,
  input wire logic temp_above_shutdown,
  input wire logic temp_below_recovery,
  // Gate drives
  output logic high_side_a,
  output logic low_side_a,
  output logic high_side_b,
  output logic low_side_b,
  // Status
  output logic asleep,
  output logic locked_out,
  output logic fault_off
);

  localparam int W = hbmp_pkg::CNT_W;

  if (SLEEP_CYCLES < 1 || SLEEP_CYCLES >= (1 << W) || DEG_CYCLES < 1 ||
      DEG_CYCLES >= (1 << W) || RETRY_CYCLES < 1 || RETRY_CYCLES >= (1 << W))
  begin
    $error("hbmp_ctrl: cycle count out of range");
  end

  hbmp_pkg::hbmp_mode_t mode;
  logic drive_mode;
  logic sleep_ff;
  logic nxt_sleep;
  logic lock_ff;
  logic nxt_lock;
  hbmp_pkg::hbmp_prot_t prot_ff;
  hbmp_pkg::hbmp_prot_t nxt_prot;
  logic [3:0] gate_ff;
  logic [3:0] nxt_gate;
  logic asleep_ff;
  logic locked_ff;
  logic fault_ff;
  logic sleep_done;
  logic deg_done;
  logic retry_done;
  logic oc_en;
  logic ot_en;
  logic retry_clear;

  always_comb
  begin
    case ({dir_in_a, dir_in_b})
      2'b10: mode = hbmp_pkg::HBMP_FORWARD;
      2'b01: mode = hbmp_pkg::HBMP_REVERSE;
      2'b11: mode = hbmp_pkg::HBMP_BRAKE;
      default: mode = hbmp_pkg::HBMP_STANDBY;
    endcase
  end

  assign drive_mode = dir_in_a ^ dir_in_b;

  // Counter restarts on any forward/reverse cycle, so brief pulses keep it awake
  hbmp_timer #(.W(W)) u_sleep_tmr
  (
    .clk(clk),
    .resetn(resetn),
    .clear(drive_mode),
    .run(!lock_ff && !sleep_ff),
    .limit(W'(SLEEP_CYCLES)),
    .done(sleep_done)
  );

  // Deglitch: over-current must persist the full interval
  hbmp_timer #(.W(W)) u_deg_tmr
  (
    .clk(clk),
    .resetn(resetn),
    .clear(1'b0),
    .run(overcurrent_det && oc_en && prot_ff == hbmp_pkg::HBMP_RUN),
    .limit(W'(DEG_CYCLES)),
    .done(deg_done)
  );

  assign retry_clear = prot_ff == hbmp_pkg::HBMP_SC_HOLD && retry_done && short_det;

  hbmp_timer #(.W(W)) u_retry_tmr
  (
    .clk(clk),
    .resetn(resetn),
    .clear(retry_clear),
    .run(prot_ff == hbmp_pkg::HBMP_OC_HOLD || prot_ff == hbmp_pkg::HBMP_SC_HOLD),
    .limit(W'(RETRY_CYCLES)),
    .done(retry_done)
  );

  // Protection enables per mode
  assign oc_en = !sleep_ff && mode != hbmp_pkg::HBMP_STANDBY;
  assign ot_en = !sleep_ff;

  always_comb
  begin
    nxt_lock = lock_ff;
    if (lock_ff && supply_above_rise)
      nxt_lock = 1'b0;
    else if (supply_below_fall)
      nxt_lock = 1'b1;
  end

  always_comb
  begin
    nxt_sleep = sleep_ff;
    if (lock_ff)
      nxt_sleep = 1'b0;
    else if (drive_mode)
      nxt_sleep = 1'b0;
    else if (sleep_done)
      nxt_sleep = 1'b1;
  end

  always_comb
  begin
    nxt_prot = prot_ff;
    case (prot_ff)
      hbmp_pkg::HBMP_RUN: nxt_prot = hbmp_pkg::HBMP_RUN;
      // Retry release only in forward/reverse; brake stays latched off
      hbmp_pkg::HBMP_OC_HOLD:
      begin
        if (retry_done && drive_mode)
          nxt_prot = hbmp_pkg::HBMP_RUN;
      end
      hbmp_pkg::HBMP_SC_HOLD:
      begin
        if (retry_done && drive_mode && !short_det)
          nxt_prot = hbmp_pkg::HBMP_RUN;
      end
      hbmp_pkg::HBMP_OT_HOLD:
      begin
        if (temp_below_recovery)
          nxt_prot = hbmp_pkg::HBMP_RUN;
      end
      default: nxt_prot = hbmp_pkg::HBMP_RUN;
    endcase
    // Entry checks also run on release, so a live over-temperature or short never opens the gates when awake; over-current must first pass the deglitch again
    if (nxt_prot == hbmp_pkg::HBMP_RUN)
    begin
      if (ot_en && temp_above_shutdown)
        nxt_prot = hbmp_pkg::HBMP_OT_HOLD;
      else if (oc_en && short_det)
        nxt_prot = hbmp_pkg::HBMP_SC_HOLD;
      else if (deg_done)
        nxt_prot = hbmp_pkg::HBMP_OC_HOLD;
    end
    if (lock_ff || sleep_ff)
      nxt_prot = hbmp_pkg::HBMP_RUN;
  end

  // Gate order: high_a, low_a, high_b, low_b
  always_comb
  begin
    case (mode)
      hbmp_pkg::HBMP_FORWARD: nxt_gate = 4'b1001;
      hbmp_pkg::HBMP_REVERSE: nxt_gate = 4'b0110;
      hbmp_pkg::HBMP_BRAKE: nxt_gate = 4'b0101;
      default: nxt_gate = 4'b0000;
    endcase
    if (nxt_lock || lock_ff)
      nxt_gate = 4'b0000;
    else if (nxt_prot != hbmp_pkg::HBMP_RUN)
      nxt_gate = 4'b0000;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_ff <= 1'b1;
      sleep_ff <= 1'b0;
      prot_ff <= hbmp_pkg::HBMP_RUN;
      gate_ff <= 4'h0;
      asleep_ff <= 1'b0;
      locked_ff <= 1'b1;
      fault_ff <= 1'b0;
    end
    else
    begin
      lock_ff <= nxt_lock;
      sleep_ff <= nxt_sleep;
      prot_ff <= nxt_prot;
      gate_ff <= nxt_gate;
      asleep_ff <= nxt_sleep;
      locked_ff <= nxt_lock;
      fault_ff <= nxt_prot != hbmp_pkg::HBMP_RUN;
    end
  end

  assign high_side_a = gate_ff[3];
  assign low_side_a = gate_ff[2];
  assign high_side_b = gate_ff[1];
  assign low_side_b = gate_ff[0];
  assign asleep = asleep_ff;
  assign locked_out = locked_ff;
  assign fault_off = fault_ff;

endmodule

//--- hbmp_pkg.sv
package hbmp_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLEEP_MS = 10;
  localparam int unsigned SLEEP_CYC = (CLK_HZ / 1000) * SLEEP_MS;
  localparam int unsigned DEG_NS = 1000;
  localparam int unsigned DEG_CYC = (DEG_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned RETRY_US = 1000;
  localparam int unsigned RETRY_CYC = RETRY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 24;

  // Decoded input combinations
  typedef enum logic [3:0]
  {
    HBMP_STANDBY = 4'b0001,
    HBMP_FORWARD = 4'b0010,
    HBMP_REVERSE = 4'b0100,
    HBMP_BRAKE = 4'b1000
  } hbmp_mode_t;

  // Protection state
  typedef enum logic [3:0]
  {
    HBMP_RUN = 4'b0001,
    HBMP_OC_HOLD = 4'b0010,
    HBMP_SC_HOLD = 4'b0100,
    HBMP_OT_HOLD = 4'b1000
  } hbmp_prot_t;

endpackage

//--- hbmp_timer.sv
`timescale 1ns/1ps
module hbmp_timer
#(
  parameter int W = 24
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [W-1:0] limit,
  // Status
  output logic done
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  if (W < 1)
  begin
    $error("hbmp_timer: counter width too small");
  end

  // Saturates at the limit so a held condition stays flagged
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (clear || !run)
      nxt_cnt = '0;
    else if (cnt_ff != limit)
      nxt_cnt = cnt_ff + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  // Not gated by clear: a restart that reads done would otherwise form a loop
  assign done = run && (cnt_ff == limit);

endmodule

//--- hbmp_checker_assertions.sv
`timescale 1ns/1ps
module hbmp_checker
#(
  parameter int unsigned DEG_CYCLES = hbmp_pkg::DEG_CYC
)
(
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic resetn,
  input wire logic dir_in_a,
  input wire logic dir_in_b,
  input wire logic supply_above_rise,
  input wire logic supply_below_fall,
  input wire logic overcurrent_det,
  input wire logic short_det,
  input wire logic temp_above_shutdown,
  input wire logic temp_below_recovery,
  // Outputs
  input wire logic high_side_a,
  input wire logic low_side_a,
  input wire logic high_side_b,
  input wire logic low_side_b,
  input wire logic asleep,
  input wire logic locked_out,
  input wire logic fault_off
);
  wire [3:0] g = {high_side_a, low_side_a, high_side_b, low_side_b};
  wire on = !locked_out && !supply_below_fall && !asleep;
  wire one = dir_in_a ^ dir_in_b;
  wire oc_cond = on && one && overcurrent_det && !fault_off;
  int unsigned oc_cnt;
  // Run length of the over-current window, follows any deglitch setting
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      oc_cnt <= 0;
    else if (oc_cond)
      oc_cnt <= oc_cnt + 1;
    else
      oc_cnt <= 0;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_fwd;
    on && !fault_off && dir_in_a && !dir_in_b |=> fault_off || g == 4'h9;
  endproperty
  a_fwd: assert property (p_fwd) else $error("fwd");
  property p_lock;
    locked_out && $past(locked_out) |-> g == 4'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_uv;
    supply_below_fall |=> locked_out ##1 g == 4'h0;
  endproperty
  a_uv: assert property (p_uv) else $error("uv");
  property p_rel;
    locked_out && supply_above_rise && !supply_below_fall |=> !locked_out;
  endproperty
  a_rel: assert property (p_rel) else $error("rel");
  property p_sc;
    on && one && short_det |=> g == 4'h0;
  endproperty
  a_sc: assert property (p_sc) else $error("sc");
  // Window restarts once released, so a long fault never misfires
  property p_oc;
    oc_cond && oc_cnt == DEG_CYCLES |=> fault_off;
  endproperty
  a_oc: assert property (p_oc) else $error("oc");
  property p_ot;
    on && temp_above_shutdown |=> g == 4'h0;
  endproperty
  a_ot: assert property (p_ot) else $error("ot");
  property p_wake;
    asleep && one |=> !asleep;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_sleep_hold;
    asleep && !one && !locked_out |=> asleep;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep hold");
  property p_sleep_prot;
    asleep |=> !fault_off;
  endproperty
  a_sleep_prot: assert property (p_sleep_prot) else $error("sleep prot");
endmodule

bind hbmp_ctrl hbmp_checker #(.DEG_CYCLES(DEG_CYCLES)) u_chk (.*);

//--- hbmp_host.sv
`timescale 1ns/1ps
module hbmp_host
(
  // Clock and command
  input wire logic clk,
  input wire logic [1:0] mode,
  // Direction pins
  output logic dir_in_a,
  output logic dir_in_b
);
  // Driven from time zero, never left floating
  initial
  begin
    {dir_in_a, dir_in_b} = 2'h0;
    forever @(negedge clk) {dir_in_a, dir_in_b} <= mode;
  end
endmodule

//--- hbridge_mode_protection_ctrl_tb.sv
`timescale 1ns/1ps
module hbridge_mode_protection_ctrl_tb;
  logic clk, resetn, rise, fall, oc, sc, hot, cool, a, b, sl, lk, fo;
  logic [1:0] mode;
  logic [3:0] g;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  hbmp_host host (.clk(clk), .mode(mode), .dir_in_a(a), .dir_in_b(b));
  hbmp_ctrl #(.SLEEP_CYCLES(50), .DEG_CYCLES(3), .RETRY_CYCLES(20)) dut (.clk(clk),
    .resetn(resetn), .dir_in_a(a), .dir_in_b(b), .supply_above_rise(rise),
    .supply_below_fall(fall), .overcurrent_det(oc), .short_det(sc),
    .temp_above_shutdown(hot), .temp_below_recovery(cool), .high_side_a(g[3]),
    .low_side_a(g[2]), .high_side_b(g[1]), .low_side_b(g[0]), .asleep(sl),
    .locked_out(lk), .fault_off(fo));
  task chk(input string s, input logic [3:0] e, v);
    tests_run++;
    if (v !== e)
    begin
      $display("ERROR %s exp %h got %h", s, e, v);
      fails++;
    end
  endtask
  task go(input logic [1:0] m, input int n);
    mode <= m;
    repeat (n) @(negedge clk);
  endtask
  task close_out;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task t_lock;
    go(2'h2, 4);
    chk("lk", 4'h1, 4'(lk));
    rise = 1'h1;
    go(2'h2, 3);
    chk("fwd", 4'h9, g);
  endtask
  task t_reset;
    resetn = 1'h0;
    go(2'h2, 2);
    chk("rst_lk", 4'h1, 4'(lk));
    chk("rst_g", 4'h0, g);
    resetn = 1'h1;
    go(2'h2, 3);
    chk("rst_fwd", 4'h9, g);
  endtask
  task t_modes;
    logic [3:0] tbl [4] = '{4'h0, 4'h6, 4'h9, 4'h5};
    for (int m = 0; m < 4; m++)
    begin
      go(m[1:0], 3);
      chk("mode", tbl[m], g);
    end
  endtask
  task t_oc;
    oc = 1'h1;
    go(2'h2, 2);
    oc = 1'h0;
    go(2'h2, 3);
    chk("glitch", 4'h9, g);
    oc = 1'h1;
    go(2'h2, 8);
    chk("oc", 4'h0, g);
    oc = 1'h0;
    go(2'h2, 25);
    chk("retry", 4'h9, g);
    oc = 1'h1;
    go(2'h3, 8);
    oc = 1'h0;
    go(2'h3, 25);
    chk("oc_brk", 4'h0, g);
    go(2'h2, 3);
    chk("oc_brk_rel", 4'h9, g);
  endtask
  task t_short;
    go(2'h1, 3);
    sc = 1'h1;
    go(2'h1, 30);
    chk("sc", 4'h0, g);
    sc = 1'h0;
    go(2'h1, 25);
    chk("sc_rec", 4'h6, g);
  endtask
  task t_temp;
    go(2'h0, 3);
    hot = 1'h1;
    cool = 1'h0;
    go(2'h0, 3);
    chk("ot", 4'h1, 4'(fo));
    hot = 1'h0;
    go(2'h2, 4);
    chk("ot_hold", 4'h0, g);
    cool = 1'h1;
    go(2'h2, 4);
    chk("ot_rec", 4'h9, g);
  endtask
  task t_sleep;
    go(2'h0, 45);
    chk("awake", 4'h0, 4'(sl));
    go(2'h0, 10);
    chk("asleep", 4'h1, 4'(sl));
    sc = 1'h1;
    go(2'h3, 4);
    chk("sl_brk", 4'h5, g);
    chk("sl_stay", 4'h1, 4'(sl));
    sc = 1'h0;
    go(2'h2, 3);
    chk("wake", 4'h0, 4'(sl));
  endtask
  task t_uv;
    fall = 1'h1;
    rise = 1'h0;
    go(2'h2, 3);
    chk("uv", 4'h1, 4'(lk));
    chk("uv_g", 4'h0, g);
  endtask
  initial
  begin
    {resetn, mode, rise, fall, oc, sc, hot, cool} = 9'h001;
    repeat (3) @(posedge clk);
    @(negedge clk);
    resetn = 1'h1;
    t_lock;
    t_reset;
    t_modes;
    t_oc;
    t_short;
    t_temp;
    t_sleep;
    t_uv;
    close_out;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      close_out;
    end
  end
endmodule
